// ### hw/fsu_pkg.sv
// Constants, types and carriers of the file settings update decoder.
// Assumes a single pclk domain shared by every file of the block.
package fsu_pkg;
	// Command code and the one file that may carry messaging.
	localparam logic [7:0] CMD_CODE = 8'h5F;
	localparam logic [4:0] DM_FILE = 5'h02;
	// Reserved masks of the header, option and messaging option bytes.
	localparam logic [7:0] FNO_RSV = 8'hE0;
	localparam logic [7:0] OPT_RSV = 8'hB4;
	localparam logic [7:0] SOPT_RSV = 8'h06;
	// Bit positions inside the option and messaging option bytes.
	localparam int OPT_DM = 6;
	localparam int OPT_DEFER = 3;
	localparam int PROT_LSB = 0;
	localparam int SOPT_UID = 7;
	localparam int SOPT_CTR = 6;
	localparam int SOPT_LIM = 5;
	localparam int SOPT_ENC = 4;
	localparam int SOPT_PIN = 3;
	localparam int SOPT_ASCII = 0;
	// Nibble positions inside the key rights word.
	localparam int KR_META = 12;
	localparam int KR_SYM = 8;
	localparam int KR_ASYM = 4;
	// Nibble codes: highest key index, plain mirroring, switched off.
	localparam logic [3:0] KEY_MAX = 4'h4;
	localparam logic [3:0] NIB_PLAIN = 4'hE;
	localparam logic [3:0] NIB_OFF = 4'hF;
	// Counter offset that switches counter mirroring off.
	localparam logic [23:0] CTR_NONE = 24'h0FFFFF;
	// Last byte index of one, two and three byte fields.
	localparam logic [1:0] IDX_BYTE = 2'h0;
	localparam logic [1:0] IDX_WORD = 2'h1;
	localparam logic [1:0] IDX_TRIPLE = 2'h2;
	// Register byte addresses.
	localparam logic [7:0] A_FSIZE = 8'h00;
	localparam logic [7:0] A_LENS = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_HDR = 8'h0C;
	localparam logic [7:0] A_DMK = 8'h10;
	localparam logic [7:0] A_UID = 8'h14;
	localparam logic [7:0] A_CTR = 8'h18;
	localparam logic [7:0] A_CARD = 8'h1C;
	// Reset values of the file geometry registers.
	localparam logic [23:0] FSIZE_RST = 24'h000100;
	localparam logic [7:0] UIDL_RST = 8'h07;
	localparam logic [7:0] CTRL_RST = 8'h03;
	localparam logic [7:0] CARDL_RST = 8'h10;
	// Parser states, one per field of the frame, then trailing bytes and foreign frames.
	typedef enum {S_CMD, S_FNO, S_OPT, S_AR, S_SOPT, S_KR, S_UID,
		S_CTR, S_CARD, S_TAIL, S_DROP} parse_st_t;
	// One received byte with its frame end mark.
	typedef struct packed {logic valid; logic last; logic [7:0] data;}
		rx_byte_t;
	// File size and the lengths of the mirrored items.
	typedef struct packed {logic [23:0] fsize; logic [7:0] uid_len;
		logic [7:0] ctr_len; logic [7:0] card_len;} geom_t;
	// Outcome flags of the last frame and the parser activity.
	typedef struct packed {logic len_err; logic par_err; logic busy;}
		status_t;
	// Every field of one decoded frame with presence marks.
	typedef struct packed {logic [7:0] fno; logic [7:0] opt;
		logic [15:0] ar; logic [7:0] sopt; logic [15:0] kr;
		logic [23:0] uid_pos; logic [23:0] ctr_pos; logic [23:0] card_pos;
		logic uid_v; logic ctr_v; logic card_v;} settings_t;
	// True when a rights nibble names one of the keys.
	function automatic logic is_key(input logic [3:0] n);
		return n <= KEY_MAX;
	endfunction
endpackage

// ### hw/fsu_apb_regs.sv
// APB slave of the decoder: geometry registers and result readback.
// Assumes APB3 signalling on pclk; answers every access after two cycles.
`timescale 1ns/1ps
`default_nettype none
module fsu_apb_regs
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Block side.
	input wire fsu_pkg::status_t stat,
	input wire fsu_pkg::settings_t set,
	output var fsu_pkg::geom_t geom
);
	import fsu_pkg::*;
	// Address decode of the eight words.
	wire a_fs = paddr == A_FSIZE;
	wire a_ln = paddr == A_LENS;
	wire a_st = paddr == A_STAT;
	wire a_hd = paddr == A_HDR;
	wire a_dk = paddr == A_DMK;
	wire a_ui = paddr == A_UID;
	wire a_ct = paddr == A_CTR;
	wire a_cd = paddr == A_CARD;
	wire hit = a_fs | a_ln | a_st | a_hd | a_dk | a_ui | a_ct | a_cd;
	// Only the geometry words take writes; the others show results.
	wire ro = a_st | a_hd | a_dk | a_ui | a_ct | a_cd;
	wire bad = ~hit | (pwrite & ro);
	// First access cycle: the answer is prepared for the next edge.
	wire first = psel & penable & ~pready;
	// The write lands on the edge where the master sees pready.
	wire commit = psel & penable & pready & pwrite & ~pslverr;
	// Read word selection; an unmapped address reads as zero.
	wire [31:0] rd = ({32{a_fs}} & {8'h00, geom.fsize})
		| ({32{a_ln}} & {8'h00, geom.card_len, geom.ctr_len, geom.uid_len})
		| ({32{a_st}} & {29'h0, stat.busy, stat.par_err, stat.len_err})
		| ({32{a_hd}} & {set.fno, set.opt, set.ar})
		| ({32{a_dk}} & {5'h0, set.card_v, set.ctr_v, set.uid_v,
			set.sopt, set.kr})
		| ({32{a_ui}} & {8'h00, set.uid_pos})
		| ({32{a_ct}} & {8'h00, set.ctr_pos})
		| ({32{a_cd}} & {8'h00, set.card_pos});
	// Answer flops: one wait state keeps the decode off the output path.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= first;
			pslverr <= first & bad;
			prdata <= first ? rd : prdata;
		end
	end
	// Geometry registers steer the offset range checks.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			geom <= {FSIZE_RST, UIDL_RST, CTRL_RST, CARDL_RST};
		else if (commit && a_fs)
			geom.fsize <= pwdata[23:0];
		else if (commit && a_ln)
			{geom.card_len, geom.ctr_len, geom.uid_len} <= pwdata[23:0];
	end
endmodule
`default_nettype wire

// ### hw/fsu_checker.sv
// Parameter checks on one decoded frame against the file geometry.
// Assumes stable inputs for the cycle in which the result is taken.
`timescale 1ns/1ps
`default_nettype none
module fsu_checker
(
	// Decoded fields and geometry.
	input wire fsu_pkg::settings_t fld,
	input wire fsu_pkg::geom_t geom,
	// High when any parameter is not allowed.
	output logic par_err
);
	import fsu_pkg::*;
	// An offset fits when the item ends inside the file.
	function automatic logic fits(input logic [23:0] pos,
		input logic [7:0] len);
		return (geom.fsize >= {16'h0, len})
			&& (pos <= geom.fsize - {16'h0, len});
	endfunction
	// Rights nibbles: keys, off, and plain only where allowed.
	wire [3:0] meta = fld.kr[KR_META +: 4];
	wire [3:0] sym = fld.kr[KR_SYM +: 4];
	wire [3:0] asym = fld.kr[KR_ASYM +: 4];
	wire meta_ok = is_key(meta) | meta == NIB_PLAIN | meta == NIB_OFF;
	wire sym_ok = is_key(sym) | sym == NIB_OFF;
	wire asym_ok = is_key(asym) | asym == NIB_OFF;
	wire dm = fld.opt[OPT_DM];
	wire on2 = fld.fno[4:0] == DM_FILE;
	// Reserved bits, including the file-2 bits on any other file.
	wire rsv = |(fld.fno & FNO_RSV) // [RULE_02]
		| |(fld.opt & OPT_RSV) // [RULE_03]
		| (fld.opt[OPT_DM] & ~on2) // [RULE_04]
		| (fld.opt[OPT_DEFER] & ~on2) // [RULE_05]
		| (dm & |(fld.sopt & SOPT_RSV)); // [RULE_09]
	// Undefined nibble values are only checked if the word came in.
	wire nib = dm & ~(meta_ok & sym_ok & asym_ok); // [RULE_10] [RULE_11] [RULE_12]
	// Offset ranges; the counter has its own switch-off value.
	wire ofs = (fld.uid_v & ~fits(fld.uid_pos, geom.uid_len)) // [RULE_13]
		| (fld.ctr_v & fld.ctr_pos != CTR_NONE // [RULE_14]
			& ~fits(fld.ctr_pos, geom.ctr_len))
		| (fld.card_v & ~fits(fld.card_pos, geom.card_len)); // [RULE_15]
	assign par_err = rsv | nib | ofs; // [RULE_17]
endmodule
`default_nettype wire

// ### hw/file_settings_update_decoder.sv
// Parser for the file settings update command with result registers.
// Assumes bytes come from link logic on pclk, one per valid cycle.
//
// Contract
// RULE_01: Command code 0x5F starts a settings update.
// RULE_02: Header byte gives file index; bits 7-5 reserved.
// RULE_03: Option bits 1-0 give the protection level.
// RULE_04: Option bit 6 enables messaging, file 2 only.
// RULE_05: Option bit 3 defers configuration, file 2 only.
// RULE_06: Two access condition bytes follow the option.
// RULE_07: Messaging options byte present only with bit 6.
// RULE_08: Key rights word present only with bit 6.
// RULE_09: Options byte feature bits; bits 2-1 reserved.
// RULE_10: Meta right nibble: keys, plain or off.
// RULE_11: Symmetric read nibble: keys or off.
// RULE_12: Asymmetric read nibble: keys or off.
// RULE_13: Unique ID offset with bit 7 and plain.
// RULE_14: Counter offset with bit 6 and plain.
// RULE_15: Card data offset when meta names a key.
// RULE_16: Fields in order; length mismatch is flagged.
// RULE_17: Reserved bits, bad nibbles, bad offsets flag errors.
`timescale 1ns/1ps
`default_nettype none
module file_settings_update_decoder
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Command bytes from the link logic.
	input wire fsu_pkg::rx_byte_t rx,
	// Result of the last accepted frame.
	output logic upd_done,
	output logic upd_len_err,
	output logic upd_par_err,
	output var fsu_pkg::settings_t upd_settings
);
	import fsu_pkg::*;

	// Last byte index of the multi-byte field held in a state.
	function automatic logic [1:0] last_idx(input parse_st_t s);
		case (s)
			S_AR, S_KR: last_idx = IDX_WORD;
			S_UID, S_CTR, S_CARD: last_idx = IDX_TRIPLE;
			default: last_idx = IDX_BYTE;
		endcase
	endfunction

	parse_st_t st_r; // Field now expected.
	parse_st_t st_nxt;
	parse_st_t nf; // Field after the current one.
	logic [1:0] cnt_r; // Byte index inside the field.
	logic [1:0] cnt_nxt;
	settings_t fld_r; // Fields of the frame in progress.
	settings_t fld_nxt;
	logic len_r; // Length fault seen in this frame.
	logic len_nxt;
	logic eval_r; // Frame ended; results are taken next edge.
	logic eval_nxt;
	logic busy_r; // Parser is inside a frame.
	geom_t geom; // File geometry from software.
	logic chk_err; // Parameter verdict on fld_r.

	// Byte strobe and data of the incoming byte.
	wire take = rx.valid;
	wire [7:0] b = rx.data;
	wire fld_end = cnt_r == last_idx(st_r);

	// Presence of the optional fields, looked at on the merged fields
	// so that the key rights word decides in its own last byte.
	wire [3:0] meta = fld_nxt.kr[KR_META +: 4];
	wire dm_on = fld_nxt.opt[OPT_DM]; // [RULE_07] [RULE_08]
	wire meta_plain = meta == NIB_PLAIN;
	wire uid_pres = fld_nxt.sopt[SOPT_UID] & meta_plain; // [RULE_13]
	wire ctr_pres = fld_nxt.sopt[SOPT_CTR] & meta_plain; // [RULE_14]
	wire card_pres = is_key(meta); // [RULE_15]

	// Later fields are not decoded here, but their bytes are legal,
	// so trailing bytes are only a length fault when none may follow.
	wire tail_ok = fld_r.opt[OPT_DEFER] | (fld_r.opt[OPT_DM]
		& (fld_r.sopt[SOPT_PIN] | fld_r.sopt[SOPT_LIM]
		| fld_r.kr[KR_SYM +: 4] != NIB_OFF)); // [RULE_16]

	// Chain of optional offsets in their fixed order.
	parse_st_t after_ctr;
	parse_st_t after_uid;
	parse_st_t after_kr;
	assign after_ctr = card_pres ? S_CARD : S_TAIL;
	assign after_uid = ctr_pres ? S_CTR : after_ctr;
	assign after_kr = uid_pres ? S_UID : after_uid;

	// Field order of the frame; S_TAIL means all fields are in.
	always_comb
	begin
		case (st_r)
			S_FNO: nf = S_OPT;
			S_OPT: nf = S_AR; // [RULE_06]
			S_AR: nf = dm_on ? S_SOPT : S_TAIL; // [RULE_07]
			S_SOPT: nf = S_KR; // [RULE_08]
			S_KR: nf = after_kr; // [RULE_16]
			S_UID: nf = after_uid;
			S_CTR: nf = after_ctr;
			default: nf = S_TAIL;
		endcase
	end

	// Merge the current byte into its field; multi-byte values come
	// least significant byte first.
	always_comb
	begin
		fld_nxt = fld_r;
		if (take)
		begin
			case (st_r)
				S_FNO:
				begin
					// A new frame clears every field of the last one.
					fld_nxt = '0;
					fld_nxt.fno = b; // [RULE_02]
				end
				S_OPT: fld_nxt.opt = b; // [RULE_03] [RULE_04] [RULE_05]
				S_AR: fld_nxt.ar[{cnt_r[0], 3'h0} +: 8] = b; // [RULE_06]
				S_SOPT: fld_nxt.sopt = b; // [RULE_09]
				S_KR: fld_nxt.kr[{cnt_r[0], 3'h0} +: 8] = b; // [RULE_10]
				S_UID:
				begin
					fld_nxt.uid_pos[{cnt_r, 3'h0} +: 8] = b; // [RULE_13]
					fld_nxt.uid_v = 1'b1;
				end
				S_CTR:
				begin
					fld_nxt.ctr_pos[{cnt_r, 3'h0} +: 8] = b; // [RULE_14]
					fld_nxt.ctr_v = 1'b1;
				end
				S_CARD:
				begin
					fld_nxt.card_pos[{cnt_r, 3'h0} +: 8] = b; // [RULE_15]
					fld_nxt.card_v = 1'b1;
				end
				default: fld_nxt = fld_r;
			endcase
		end
	end

	// Frame sequencing: command match, field steps, end of frame.
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		eval_nxt = 1'b0;
		if (take)
		begin
			case (st_r)
				S_CMD:
				begin
					len_nxt = 1'b0;
					cnt_nxt = IDX_BYTE;
					if (b != CMD_CODE) // [RULE_01]
						st_nxt = rx.last ? S_CMD : S_DROP;
					else if (rx.last)
					begin
						// A bare command byte is too short.
						len_nxt = 1'b1; // [RULE_16]
						eval_nxt = 1'b1;
					end
					else
						st_nxt = S_FNO;
				end
				// Foreign commands are skipped without any result.
				S_DROP: st_nxt = rx.last ? S_CMD : S_DROP;
				S_TAIL:
				begin
					if (!tail_ok)
						len_nxt = 1'b1; // [RULE_16]
					if (rx.last)
					begin
						st_nxt = S_CMD;
						eval_nxt = 1'b1;
					end
				end
				default:
				begin
					if (rx.last)
					begin
						// The frame must end on the last expected byte.
						st_nxt = S_CMD;
						eval_nxt = 1'b1;
						len_nxt = len_r | ~(fld_end & nf == S_TAIL); // [RULE_16]
					end
					else if (fld_end)
					begin
						st_nxt = nf;
						cnt_nxt = IDX_BYTE;
					end
					else
						cnt_nxt = cnt_r + 2'h1;
				end
			endcase
		end
	end

	// Parser state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= S_CMD;
			cnt_r <= IDX_BYTE;
			fld_r <= '0;
			len_r <= 1'b0;
			eval_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			fld_r <= fld_nxt;
			len_r <= len_nxt;
			eval_r <= eval_nxt;
			busy_r <= st_nxt != S_CMD;
		end
	end

	// Results are taken one cycle after the last byte, so the checker
	// sees settled fields; a new frame may start in that same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			upd_done <= 1'b0;
			upd_len_err <= 1'b0;
			upd_par_err <= 1'b0;
			upd_settings <= '0;
		end
		else
		begin
			upd_done <= eval_r;
			if (eval_r)
			begin
				upd_len_err <= len_r; // [RULE_16]
				upd_par_err <= chk_err; // [RULE_17]
				upd_settings <= fld_r;
			end
		end
	end

	// Parameter checks on the finished frame.
	fsu_checker u_chk
	(
		.fld(fld_r),
		.geom(geom),
		.par_err(chk_err)
	);

	// Register port.
	fsu_apb_regs u_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.stat({upd_len_err, upd_par_err, busy_r}),
		.set(upd_settings),
		.geom(geom)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cmd_gate_a: assert property ( // [RULE_01]
		(st_r == S_CMD && take && !rx.last && b != CMD_CODE)
		|=> st_r == S_DROP ##0 !eval_r)
		else $error("Foreign command was not dropped.");
	fno_take_a: assert property ( // [RULE_02]
		(st_r == S_FNO && take) |=> fld_r.fno == $past(b))
		else $error("File number byte not captured.");
	prot_take_a: assert property ( // [RULE_03]
		(st_r == S_OPT && take) |=> st_r != S_OPT
		&& fld_r.opt[PROT_LSB +: 2] == $past(b[PROT_LSB +: 2]))
		else $error("Protection level not captured.");
	dm_file_a: assert property ( // [RULE_04]
		(upd_done && !upd_par_err && upd_settings.opt[OPT_DM])
		|-> upd_settings.fno[4:0] == DM_FILE)
		else $error("Messaging accepted on a wrong file.");
	defer_file_a: assert property ( // [RULE_05]
		(upd_done && !upd_par_err && upd_settings.opt[OPT_DEFER])
		|-> upd_settings.fno[4:0] == DM_FILE)
		else $error("Deferral accepted on a wrong file.");
	ar_order_a: assert property ( // [RULE_06]
		(st_r == S_OPT && take && !rx.last) |=> st_r == S_AR
		&& cnt_r == IDX_BYTE)
		else $error("Access conditions not taken in order.");
	ar_word_a: assert property ( // [RULE_06]
		(st_r == S_AR && cnt_r == IDX_BYTE && take && !rx.last)
		|=> st_r == S_AR && cnt_r == IDX_WORD)
		else $error("Second access byte not expected.");
	opt_skip_a: assert property ( // [RULE_07]
		(st_r == S_AR && fld_end && take && !rx.last && !dm_on)
		|=> st_r == S_TAIL)
		else $error("Options byte expected without messaging.");
	kr_next_a: assert property ( // [RULE_08]
		(st_r == S_SOPT && take && !rx.last) |=> st_r == S_KR)
		else $error("Key rights word not expected.");
	uid_path_a: assert property ( // [RULE_13]
		(st_r == S_KR && fld_end && take && !rx.last && uid_pres)
		|=> st_r == S_UID)
		else $error("Unique ID offset not expected.");
	card_path_a: assert property ( // [RULE_15]
		(st_r == S_KR && fld_end && take && !rx.last && card_pres)
		|=> st_r == S_CARD)
		else $error("Card data offset not expected.");
	short_len_a: assert property ( // [RULE_16]
		(st_r == S_OPT && take && rx.last)
		|-> ##2 upd_done && upd_len_err)
		else $error("Short frame not flagged.");
	ctr_range_a: assert property ( // [RULE_14]
		(upd_done && !upd_par_err && upd_settings.ctr_v
		&& upd_settings.ctr_pos != CTR_NONE)
		|-> upd_settings.ctr_pos <= geom.fsize - {16'h0, geom.ctr_len})
		else $error("Counter offset out of range accepted.");
	sopt_rsv_a: assert property ( // [RULE_09]
		(upd_done && !upd_par_err && upd_settings.opt[OPT_DM])
		|-> (upd_settings.sopt & SOPT_RSV) == 8'h00)
		else $error("Reserved option bits accepted.");
	nib_ok_a: assert property ( // [RULE_11]
		(upd_done && !upd_par_err && upd_settings.opt[OPT_DM])
		|-> upd_settings.kr[KR_SYM +: 4] <= KEY_MAX
		|| upd_settings.kr[KR_SYM +: 4] == NIB_OFF)
		else $error("Undefined read right accepted.");
	rsv_flag_a: assert property ( // [RULE_17]
		(eval_r && |(fld_r.fno & FNO_RSV)) |=> upd_par_err)
		else $error("Reserved file bits not flagged.");

	ok_dm_c: cover property (upd_done && !upd_par_err && !upd_len_err
		&& upd_settings.uid_v);
	ok_card_c: cover property (upd_done && upd_settings.card_v);
	len_err_c: cover property (upd_done && upd_len_err);
	drop_c: cover property (st_r == S_DROP ##1 st_r == S_CMD);
endmodule
`default_nettype wire

// ### sim/fsu_host.sv
// Host side model: sends command frames a byte at a time on rx.
// Assumes the decoder takes every valid byte on the rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module fsu_host
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Byte stream towards the decoder.
	output var fsu_pkg::rx_byte_t rx
);
	import fsu_pkg::*;
	// Idle line: valid low and data toggling, so a stale byte never looks real.
	initial rx = '{valid: 1'b0, last: 1'b0, data: 8'hFF};
	// One idle cycle with inverted data.
	task automatic rest();
		@(posedge pclk);
		rx <= '{valid: 1'b0, last: 1'b0, data: ~rx.data};
	endtask
	// Sends a whole frame; gap idle cycles after each byte model a slow host.
	task automatic send(input logic [7:0] b[$], input int gap);
		wait (presetn === 1'b1);
		for (int i = 0; i < b.size(); i++)
		begin
			@(posedge pclk);
			rx <= '{valid: 1'b1, last: i == b.size() - 1, data: b[i]};
			repeat (gap) rest();
		end
	endtask
endmodule
`default_nettype wire

// ### sim/file_settings_update_decoder_tb.sv
// Self-checking bench of the settings update decoder.
// Assumes the host model in fsu_host.sv and the APB map of the package.
`timescale 1ns/1ps
`default_nettype none
module file_settings_update_decoder_tb;
	import fsu_pkg::*;
	// One expected frame outcome; full asks for a field compare too.
	typedef struct packed {logic lerr; logic perr; logic full; settings_t s;} note_t;
	localparam int LIMIT = 20000;
	logic pclk = 1'b0;
	logic presetn;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	rx_byte_t rx;
	logic upd_done, upd_len_err, upd_par_err;
	settings_t upd_settings;
	note_t notes[$];
	note_t cur;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int last_at = 0;
	// 125 MHz clock.
	always #4 pclk = ~pclk;
	fsu_host host (.pclk(pclk), .presetn(presetn), .rx(rx));
	file_settings_update_decoder dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx(rx), .upd_done(upd_done), .upd_len_err(upd_len_err),
		.upd_par_err(upd_par_err), .upd_settings(upd_settings));
	// Reports and counts a mismatch.
	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Random source of the bench.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Clears fields that the frame did not carry, as their value is free.
	function automatic settings_t mask(input settings_t s, input settings_t e);
		if (!e.opt[OPT_DM])
		begin
			s.sopt = 8'h00;
			s.kr = 16'h0000;
		end
		if (!e.uid_v) s.uid_pos = 24'h000000;
		if (!e.ctr_v) s.ctr_pos = 24'h000000;
		if (!e.card_v) s.card_pos = 24'h000000;
		return s;
	endfunction
	// One APB transfer; waits on pready, only the bench timeout ends it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] er, input logic ee);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		if (!w) check(prdata, er);
		check(pslverr, ee);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Builds a frame from its fields, notes the outcome and sends it.
	task automatic frame(input logic [7:0] fno, input logic [7:0] opt,
		input logic [7:0] sopt, input logic [15:0] kr, input logic [23:0] up,
		input logic [23:0] cp, input int cut, input logic perr);
		logic [7:0] q[$];
		note_t e;
		logic m6;
		rnd = lfsr(rnd);
		m6 = opt[OPT_DM];
		e = '0;
		e.s.fno = fno;
		e.s.opt = opt;
		e.s.ar = rnd[15:0];
		e.s.sopt = sopt;
		e.s.kr = kr;
		e.s.uid_v = m6 && sopt[SOPT_UID] && kr[15:12] == NIB_PLAIN;
		e.s.ctr_v = m6 && sopt[SOPT_CTR] && kr[15:12] == NIB_PLAIN;
		e.s.card_v = m6 && kr[15:12] <= KEY_MAX;
		e.s.uid_pos = up;
		e.s.card_pos = up;
		e.s.ctr_pos = cp;
		q = '{CMD_CODE, fno, opt, rnd[7:0], rnd[15:8]};
		if (m6) q = {q, sopt, kr[7:0], kr[15:8]};
		if (e.s.uid_v) q = {q, up[7:0], up[15:8], up[23:16]};
		if (e.s.ctr_v) q = {q, cp[7:0], cp[15:8], cp[23:16]};
		if (e.s.card_v) q = {q, up[7:0], up[15:8], up[23:16]};
		if (cut < 0) void'(q.pop_back());
		if (cut > 0) q.push_back(8'hA5);
		e.lerr = cut != 0;
		e.perr = perr;
		e.full = cut == 0 && !perr;
		notes.push_back(e);
		host.send(q, int'(rnd[17:16]));
	endtask
	// Watcher: each done takes the oldest note and compares.
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (rx.valid && rx.last) last_at <= cyc;
		if (presetn && upd_done === 1'b1)
		begin
			if (notes.size() == 0)
				check(1'b1, 1'b0);
			else
			begin
				cur = notes.pop_front();
				check(cyc - last_at, 2);
				check({upd_len_err, upd_par_err}, {cur.lerr, cur.perr});
				if (cur.full) check(mask(upd_settings, cur.s), mask(cur.s, cur.s));
			end
		end
		// The ceiling is tested last, so nothing runs after the verdict.
		if (cyc == LIMIT)
		begin
			err_count++;
			conclude();
		end
	end
	// Main sequence: reset, registers, then frames of every kind.
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		presetn = 1'b0;
		rnd = 32'h89B0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_FSIZE, 32'h0, 32'h00000100, 1'b0);
		apb(1'b0, A_LENS, 32'h0, 32'h00100307, 1'b0);
		apb(1'b1, A_FSIZE, 32'h00000040, 32'h0, 1'b0);
		apb(1'b0, A_FSIZE, 32'h0, 32'h00000040, 1'b0);
		apb(1'b1, A_STAT, 32'h00000007, 32'h0, 1'b1);
		apb(1'b0, 8'h40, 32'h0, 32'h00000000, 1'b1);
		// Every protection level on a random file, no messaging.
		for (int p = 0; p < 4; p++)
		begin
			rnd = lfsr(rnd);
			frame({3'h0, rnd[4:0]}, p[7:0], 8'h00, 16'hFFFF, 0, 0, 0, 1'b0);
		end
		frame(8'h02, 8'h40, 8'hF9, 16'hEFFF, 24'h39, 24'h0FFFFF, 0, 1'b0);
		frame(8'h02, 8'h40, 8'h40, 16'h3F4E, 24'h30, 0, 0, 1'b0);
		frame(8'h02, 8'h40, 8'h80, 16'hEFFF, 24'h3A, 0, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h40, 16'hEFFF, 0, 24'h3E, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h00, 16'h3FFF, 24'h31, 0, 0, 1'b1);
		frame(8'h22, 8'h00, 8'h00, 0, 0, 0, 0, 1'b1);
		frame(8'h01, 8'h80, 8'h00, 0, 0, 0, 0, 1'b1);
		frame(8'h01, 8'h10, 8'h00, 0, 0, 0, 0, 1'b1);
		frame(8'h01, 8'h04, 8'h00, 0, 0, 0, 0, 1'b1);
		frame(8'h03, 8'h08, 8'h00, 0, 0, 0, 0, 1'b1);
		frame(8'h03, 8'h40, 8'h00, 16'hFFFF, 0, 0, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h02, 16'hFFFF, 0, 0, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h00, 16'h5FFF, 0, 0, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h00, 16'hF7FF, 0, 0, 0, 1'b1);
		frame(8'h02, 8'h40, 8'h00, 16'hFFAF, 0, 0, 0, 1'b1);
		frame(8'h01, 8'h00, 8'h00, 0, 0, 0, -1, 1'b0);
		frame(8'h01, 8'h00, 8'h00, 0, 0, 0, 1, 1'b0);
		frame(8'h02, 8'h40, 8'h80, 16'hEFFF, 24'h01, 0, -1, 1'b0);
		// A frame cut after the option byte, then deferral on file 2,
		// whose trailing bytes are legal and no length fault.
		notes.push_back('{lerr: 1'b1, default: '0});
		host.send('{CMD_CODE, 8'h01, 8'h00}, 0);
		notes.push_back('{default: '0});
		host.send('{CMD_CODE, 8'h02, 8'h08, 8'h11, 8'h22,
			8'h00, 8'h00}, 0);
		// A foreign code is dropped whole; a good frame follows at once.
		host.send('{8'h5E, 8'h01, 8'h00, 8'h11, 8'h22}, 0);
		frame(8'h05, 8'h01, 8'h00, 0, 0, 0, 0, 1'b0);
		host.rest();
		repeat (6) @(posedge pclk);
		apb(1'b0, A_STAT, 32'h0, 32'h00000000, 1'b0);
		apb(1'b0, A_HDR, 32'h0, {8'h05, 8'h01, rnd[15:0]}, 1'b0);
		check(notes.size(), 0);
		conclude();
	end
endmodule
`default_nettype wire
